// ---- common/scx_defines.vh ----
// Constants shared by the expander control path: timing, states, register map.
`ifndef SCX_DEFINES_VH
`define SCX_DEFINES_VH

// Core clock period in nanoseconds.
`define SCX_CLK_NS        10
// Power-on reset stretch in cycles.
`define SCX_POR_CYC       4'hf
`define SCX_POR_W         4

// Leading-edge filter hold: 50 ns at the 10 ns core clock, sized to the counters.
`define SCX_FILT_CYC      8'h05
// Line recovery after the last release: 100 ns at the 10 ns core clock.
`define SCX_REC_CYC       8'h0a
// Bus free settle time: 800 ns at the 10 ns core clock.
`define SCX_FREE_CYC      8'h50
`define SCX_CNT_W         8

// Forwarding channel states.
`define SCX_ST_IDLE       2'h0
`define SCX_ST_A2B        2'h1
`define SCX_ST_B2A        2'h2
`define SCX_ST_REC        2'h3

// Forwarded line indices.
`define SCX_LN_CD         0
`define SCX_LN_IO         1
`define SCX_LN_MSG        2
`define SCX_LN_ATN        3
`define SCX_LN_SEL        4
`define SCX_NLINES        5
`define SCX_NDATA         18

// Register map, byte addresses.
`define SCX_ADDR_W        12
`define SCX_REG_CTRL      12'h000
`define SCX_REG_STAT      12'h004
`define SCX_CTRL_RST      32'h0000_0001
// Control field: software transfer permit.
`define SCX_CTRL_ALLOW    0
// Status fields.
`define SCX_ST_PASS       0
`define SCX_ST_FREE       1
`define SCX_ST_BDRV_LO    2
`define SCX_ST_ADRV_LO    7
`define SCX_ST_BOK        12
`define SCX_ST_DIFF       13

`endif

// ---- rtl/scx_fwd_chan.v ----
// One forwarded bus control line between side A and side B.
`timescale 1ns/1ps
`default_nettype none
`include "scx_defines.vh"

module scx_fwd_chan (
  input  wire core_clk_i,
  input  wire rst_n_i,
  input  wire en_i,
  input  wire b_ok_i,
  input  wire a_rx_n_i,
  input  wire b_rx_n_i,
  output reg  a_pd_o,
  output reg  a_pu_oe_o,
  output reg  b_pd_o,
  output reg  b_pu_oe_o,
  output reg  b_dir_o
);

  reg  [1:0]            state_r;
  reg  [1:0]            state_nxt;
  reg  [`SCX_CNT_W-1:0] cnt_r;
  reg  [`SCX_CNT_W-1:0] cnt_nxt;
  wire                  a_act;
  wire                  b_act;

  // A level that this channel itself pulls low is never taken as a request.
  assign a_act = ~a_rx_n_i & ~a_pd_o;
  assign b_act = ~b_rx_n_i & ~b_pd_o & b_ok_i;

  always @* begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    case (state_r)
      `SCX_ST_IDLE: begin
        // Side A wins a tie, so a double assertion only drives side B.
        if (en_i && a_act) begin
          state_nxt = `SCX_ST_A2B;
          cnt_nxt   = `SCX_FILT_CYC;
        end else if (en_i && b_act) begin
          state_nxt = `SCX_ST_B2A;
          cnt_nxt   = `SCX_FILT_CYC;
        end
      end
      `SCX_ST_A2B: begin
        if (cnt_r != {`SCX_CNT_W{1'b0}}) begin
          cnt_nxt = cnt_r - 1'b1;
        end
        if (!b_ok_i || (cnt_r == {`SCX_CNT_W{1'b0}} && (!a_act || !en_i))) begin
          state_nxt = `SCX_ST_REC;
          cnt_nxt   = `SCX_REC_CYC;
        end
      end
      `SCX_ST_B2A: begin
        if (cnt_r != {`SCX_CNT_W{1'b0}}) begin
          cnt_nxt = cnt_r - 1'b1;
        end
        if (cnt_r == {`SCX_CNT_W{1'b0}} && (!b_act || !en_i)) begin
          state_nxt = `SCX_ST_REC;
          cnt_nxt   = `SCX_REC_CYC;
        end
      end
      `SCX_ST_REC: begin
        if (cnt_r == {`SCX_CNT_W{1'b0}}) begin
          state_nxt = `SCX_ST_IDLE;
        end else begin
          cnt_nxt = cnt_r - 1'b1;
        end
      end
      default: begin
        state_nxt = `SCX_ST_IDLE;
      end
    endcase
  end

  // The line is released by an active pull-up for one cycle, then three-stated.
  always @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      state_r   <= `SCX_ST_IDLE;
      cnt_r     <= {`SCX_CNT_W{1'b0}};
      a_pd_o    <= 1'b0;
      a_pu_oe_o <= 1'b0;
      b_pd_o    <= 1'b0;
      b_pu_oe_o <= 1'b0;
      b_dir_o   <= 1'b0;
    end else begin
      state_r   <= state_nxt;
      cnt_r     <= cnt_nxt;
      a_pd_o    <= (state_nxt == `SCX_ST_B2A);
      a_pu_oe_o <= (state_r == `SCX_ST_B2A) && (state_nxt == `SCX_ST_REC);
      b_pd_o    <= (state_nxt == `SCX_ST_A2B) && b_ok_i;
      b_pu_oe_o <= (state_r == `SCX_ST_A2B) && (state_nxt == `SCX_ST_REC) && b_ok_i;
      b_dir_o   <= b_ok_i && ((state_nxt == `SCX_ST_A2B) ||
                   ((state_r == `SCX_ST_A2B) && (state_nxt == `SCX_ST_REC)));
    end
  end

endmodule
`default_nettype wire

// ---- rtl/scx_expander_ctrl.v ----
// Control path of a two-sided parallel bus expander with an APB register port.
//
// The implementer's own choices: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "scx_defines.vh"

////////////////////////////////////////////////////////////////////////////////
////////////////////////////////////////////////////////////////////////////////

module scx_expander_ctrl (
  input  wire                    core_clk_i,
  input  wire                    rst_n_i,
  // APB slave.
  input  wire                    psel_i,
  input  wire                    penable_i,
  input  wire                    pwrite_i,
  input  wire [`SCX_ADDR_W-1:0]  paddr_i,
  input  wire [31:0]             pwdata_i,
  output reg  [31:0]             prdata_o,
  output reg                     pready_o,
  output reg                     pslverr_o,
  // Side A received levels, active low.
  input  wire                    a_side_command_data_n_i,
  input  wire                    a_side_direction_phase_n_i,
  input  wire                    a_side_message_phase_n_i,
  input  wire                    a_side_attention_n_i,
  input  wire                    a_side_select_n_i,
  input  wire                    a_side_busy_n_i,
  // Side B received levels, active low.
  input  wire                    b_side_command_data_n_i,
  input  wire                    b_side_direction_phase_n_i,
  input  wire                    b_side_message_phase_n_i,
  input  wire                    b_side_attention_n_i,
  input  wire                    b_side_select_n_i,
  input  wire                    b_side_busy_n_i,
  // Straps and control pins.
  input  wire                    balanced_transceiver_mode_n_i,
  input  wire                    single_ended_detect_i,
  input  wire                    warm_start_allow_i,
  output reg                     passthrough_on_o,
  // Side A drive controls, index order cd, io, msg, atn, sel.
  output wire [`SCX_NLINES-1:0]  a_pull_down_o,
  output wire [`SCX_NLINES-1:0]  a_pull_up_oe_o,
  // Side B drive controls, same order.
  output wire [`SCX_NLINES-1:0]  b_pull_down_o,
  output wire [`SCX_NLINES-1:0]  b_pull_up_oe_o,
  // Side B external transceiver direction controls.
  output reg  [`SCX_NDATA-1:0]   b_data_parity_drive_en_o,
  output reg                     b_busy_drive_en_o,
  output reg                     b_select_drive_en_o,
  output reg                     b_command_data_drive_en_o,
  output reg                     b_direction_phase_drive_en_o,
  output reg                     b_message_drive_en_o,
  output reg                     b_request_drive_en_o,
  output reg                     b_acknowledge_drive_en_o,
  output reg                     b_attention_drive_en_o,
  output reg                     b_bus_reset_drive_en_o
);

  ////////////////////////////////////////////////////////////////////////////////
  // Reset: the pin and a power-on stretcher. The stretcher relies on the
  // register power-up value, the one place where no pin is needed to start.

  reg  [`SCX_POR_W-1:0]  por_cnt_r = {`SCX_POR_W{1'b0}};
  reg                    por_done_r = 1'b0;
  wire                   rst_int_n;

  always @(posedge core_clk_i) begin
    if (!por_done_r) begin
      por_cnt_r <= por_cnt_r + 1'b1;
    end
    if (por_cnt_r == `SCX_POR_CYC) begin
      por_done_r <= 1'b1;
    end
  end

  assign rst_int_n = rst_n_i & por_done_r;

  ////////////////////////////////////////////////////////////////////////////////
  // Mode decode.

  wire                   balanced_transceiver_mode_n;
  wire                   b_ok;

  assign balanced_transceiver_mode_n = ~balanced_transceiver_mode_n_i;
  // A single-ended device on the differential side would be damaged by our drivers.
  assign b_ok = ~balanced_transceiver_mode_n | single_ended_detect_i;

  ////////////////////////////////////////////////////////////////////////////////
  // Register file.

  reg  [31:0]            ctrl_r;
  reg  [31:0]            rdata_nxt;
  reg                    err_nxt;
  wire                   apb_access;
  wire                   apb_write;
  wire                   sw_allow;

  assign apb_access = psel_i & penable_i & ~pready_o;
  // A write lands at the edge that ends the access, where the master sees pready high.
  assign apb_write  = psel_i & penable_i & pwrite_i & pready_o;
  assign sw_allow   = ctrl_r[`SCX_CTRL_ALLOW];

  ////////////////////////////////////////////////////////////////////////////////
  // Forwarded lines.

  wire [`SCX_NLINES-1:0] a_rx_n;
  wire [`SCX_NLINES-1:0] b_rx_n;
  wire [`SCX_NLINES-1:0] b_dir;

  assign a_rx_n[`SCX_LN_CD]  = a_side_command_data_n_i;
  assign a_rx_n[`SCX_LN_IO]  = a_side_direction_phase_n_i;
  assign a_rx_n[`SCX_LN_MSG] = a_side_message_phase_n_i;
  assign a_rx_n[`SCX_LN_ATN] = a_side_attention_n_i;
  assign a_rx_n[`SCX_LN_SEL] = a_side_select_n_i;
  assign b_rx_n[`SCX_LN_CD]  = b_side_command_data_n_i;
  assign b_rx_n[`SCX_LN_IO]  = b_side_direction_phase_n_i;
  assign b_rx_n[`SCX_LN_MSG] = b_side_message_phase_n_i;
  assign b_rx_n[`SCX_LN_ATN] = b_side_attention_n_i;
  assign b_rx_n[`SCX_LN_SEL] = b_side_select_n_i;

  // Select runs through the same channel as the phase lines.
  genvar gi;
  generate
    for (gi = 0; gi < `SCX_NLINES; gi = gi + 1) begin : g_line
      scx_fwd_chan u_chan (
        .core_clk_i (core_clk_i),
        .rst_n_i    (rst_int_n),
        .en_i       (passthrough_on_o),
        .b_ok_i     (b_ok),
        .a_rx_n_i   (a_rx_n[gi]),
        .b_rx_n_i   (b_rx_n[gi]),
        .a_pd_o     (a_pull_down_o[gi]),
        .a_pu_oe_o  (a_pull_up_oe_o[gi]),
        .b_pd_o     (b_pull_down_o[gi]),
        .b_pu_oe_o  (b_pull_up_oe_o[gi]),
        .b_dir_o    (b_dir[gi])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // Bus free detection. Our own select drive shows up on the received levels,
  // so an active select forwarding never counts as a free bus.

  reg  [`SCX_CNT_W-1:0]  free_cnt_r;
  reg                    bus_free_r;
  wire                   bus_idle;

  assign bus_idle = a_side_busy_n_i & b_side_busy_n_i &
                    a_side_select_n_i & (b_side_select_n_i | ~b_ok);

  always @(posedge core_clk_i) begin
    if (!rst_int_n) begin
      free_cnt_r <= {`SCX_CNT_W{1'b0}};
      bus_free_r <= 1'b0;
    end else if (!bus_idle) begin
      free_cnt_r <= {`SCX_CNT_W{1'b0}};
      bus_free_r <= 1'b0;
    end else if (free_cnt_r == `SCX_FREE_CYC) begin
      bus_free_r <= 1'b1;
    end else begin
      free_cnt_r <= free_cnt_r + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Transfer enable. The permit is sampled only while the bus is free, so a
  // change in the middle of a transfer waits for that transfer to end.

  always @(posedge core_clk_i) begin
    if (!rst_int_n) begin
      passthrough_on_o <= 1'b0;
    end else if (bus_free_r && bus_idle) begin
      // The free flag lags the lines by one cycle; a busy seen now must win.
      passthrough_on_o <= warm_start_allow_i & sw_allow;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Side B direction controls. They stay low unless the differential side is
  // enabled; paths not handled here leave their transceivers receiving.

  always @(posedge core_clk_i) begin
    if (!rst_int_n) begin
      b_data_parity_drive_en_o     <= {`SCX_NDATA{1'b0}};
      b_busy_drive_en_o            <= 1'b0;
      b_select_drive_en_o          <= 1'b0;
      b_command_data_drive_en_o    <= 1'b0;
      b_direction_phase_drive_en_o <= 1'b0;
      b_message_drive_en_o         <= 1'b0;
      b_request_drive_en_o         <= 1'b0;
      b_acknowledge_drive_en_o     <= 1'b0;
      b_attention_drive_en_o       <= 1'b0;
      b_bus_reset_drive_en_o       <= 1'b0;
    end else begin
      // The channel's direction is registered with its pull-down; this stage adds
      // one cycle, so the transceiver turns one cycle after the drive.
      b_data_parity_drive_en_o     <= {`SCX_NDATA{1'b0}};
      b_busy_drive_en_o            <= 1'b0;
      b_select_drive_en_o          <= balanced_transceiver_mode_n & b_dir[`SCX_LN_SEL];
      b_command_data_drive_en_o    <= balanced_transceiver_mode_n & b_dir[`SCX_LN_CD];
      b_direction_phase_drive_en_o <= balanced_transceiver_mode_n & b_dir[`SCX_LN_IO];
      b_message_drive_en_o         <= balanced_transceiver_mode_n & b_dir[`SCX_LN_MSG];
      b_request_drive_en_o         <= 1'b0;
      b_acknowledge_drive_en_o     <= 1'b0;
      b_attention_drive_en_o       <= balanced_transceiver_mode_n & b_dir[`SCX_LN_ATN];
      b_bus_reset_drive_en_o       <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // APB slave: one wait state on every access; unmapped addresses answer
  // with an error and read as zero, and writes to them are dropped.

  always @* begin
    rdata_nxt = 32'h0000_0000;
    err_nxt   = 1'b0;
    case (paddr_i)
      `SCX_REG_CTRL: begin
        rdata_nxt = ctrl_r;
      end
      `SCX_REG_STAT: begin
        rdata_nxt[`SCX_ST_PASS] = passthrough_on_o;
        rdata_nxt[`SCX_ST_FREE] = bus_free_r;
        rdata_nxt[`SCX_ST_BDRV_LO +: `SCX_NLINES] = b_pull_down_o;
        rdata_nxt[`SCX_ST_ADRV_LO +: `SCX_NLINES] = a_pull_down_o;
        rdata_nxt[`SCX_ST_BOK]  = b_ok;
        rdata_nxt[`SCX_ST_DIFF] = balanced_transceiver_mode_n;
      end
      default: begin
        err_nxt = 1'b1;
      end
    endcase
  end

  always @(posedge core_clk_i) begin
    if (!rst_int_n) begin
      ctrl_r    <= `SCX_CTRL_RST;
      prdata_o  <= 32'h0000_0000;
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
    end else begin
      pready_o  <= apb_access;
      pslverr_o <= apb_access & err_nxt;
      if (apb_access && !pwrite_i) begin
        prdata_o <= rdata_nxt;
      end else begin
        prdata_o <= 32'h0000_0000;
      end
      // Writes commit at the edge that completes the access phase.
      if (apb_write && paddr_i == `SCX_REG_CTRL) begin
        ctrl_r <= {31'h0000_0000, pwdata_i[`SCX_CTRL_ALLOW]};
      end
    end
  end

endmodule
`default_nettype wire

// ---- tb/scx_expander_ctrl_monitor.sv ----
// Port-level checks for the expander control path.
`timescale 1ns/1ps
`default_nettype none
`include "scx_defines.vh"

module scx_expander_ctrl_monitor (
  input wire logic                   core_clk_i,
  input wire logic                   rst_n_i,
  input wire logic                   a_side_select_n_i,
  input wire logic                   a_side_busy_n_i,
  input wire logic                   b_side_select_n_i,
  input wire logic                   b_side_busy_n_i,
  input wire logic                   balanced_transceiver_mode_n_i,
  input wire logic                   single_ended_detect_i,
  input wire logic                   warm_start_allow_i,
  input wire logic                   passthrough_on_o,
  input wire logic [`SCX_NLINES-1:0] a_pull_down_o,
  input wire logic [`SCX_NLINES-1:0] b_pull_down_o,
  input wire logic [`SCX_NLINES-1:0] b_pull_up_oe_o,
  input wire logic [`SCX_NDATA-1:0]  b_data_parity_drive_en_o,
  input wire logic                   b_busy_drive_en_o,
  input wire logic                   b_select_drive_en_o
);
  logic [7:0] idle_cnt_r;

  default clocking mon_cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);

  // Saturating run length of bus idle; with side B enabled the design may only see idle later, never sooner.
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i || !(a_side_select_n_i && b_side_select_n_i && a_side_busy_n_i && b_side_busy_n_i)) begin
      idle_cnt_r <= 8'h00;
    end else if (idle_cnt_r != 8'hff) begin
      idle_cnt_r <= idle_cnt_r + 8'h01;
    end
  end

  a_no_dual_drive: assert property ((a_pull_down_o & b_pull_down_o) == 5'h00)
    else $error("line driven on both sides");
  a_filter_hold: assert property ($rose(b_pull_down_o[4]) |-> b_pull_down_o[4] [*6])
    else $error("select output shorter than filter time");
  a_pullup_pulse: assert property ($fell(b_pull_down_o[4]) |-> b_pull_up_oe_o[4] ##1 !b_pull_up_oe_o[4])
    else $error("pull-up pulse missing at release");
  a_line_recovery: assert property ($fell(b_pull_down_o[4]) |-> !(a_pull_down_o[4] || b_pull_down_o[4]) [*8])
    else $error("select driven during recovery");
  a_unused_dir: assert property (b_data_parity_drive_en_o == 18'h00000 && !b_busy_drive_en_o)
    else $error("unused direction control active");
  a_dir_follows: assert property (!balanced_transceiver_mode_n_i && single_ended_detect_i && $past(single_ended_detect_i)
    |-> b_select_drive_en_o == $past(b_pull_down_o[4] | b_pull_up_oe_o[4]))
    else $error("select direction does not follow drive");
  a_single_quiet: assert property (balanced_transceiver_mode_n_i && $past(balanced_transceiver_mode_n_i)
    |-> !b_select_drive_en_o)
    else $error("direction control active in single-ended mode");
  a_b_side_off: assert property (!balanced_transceiver_mode_n_i && !single_ended_detect_i && !$past(single_ended_detect_i)
    |-> b_pull_down_o == 5'h00)
    else $error("side B driven while disabled");
  a_reset_idle: assert property ($rose(rst_n_i) |-> !passthrough_on_o && (a_pull_down_o | b_pull_down_o) == 5'h00)
    else $error("outputs not passive after reset");
  a_pass_at_free: assert property ($changed(passthrough_on_o) |-> idle_cnt_r >= 8'h50)
    else $error("transfer-active changed without bus free");
  a_pass_rise_ws: assert property ($rose(passthrough_on_o) |-> $past(warm_start_allow_i))
    else $error("transfer-active rose with warm start low");
endmodule

bind scx_expander_ctrl scx_expander_ctrl_monitor scx_expander_ctrl_monitor_inst (
  .core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
  .a_side_select_n_i(a_side_select_n_i), .a_side_busy_n_i(a_side_busy_n_i),
  .b_side_select_n_i(b_side_select_n_i), .b_side_busy_n_i(b_side_busy_n_i),
  .balanced_transceiver_mode_n_i(balanced_transceiver_mode_n_i), .single_ended_detect_i(single_ended_detect_i),
  .warm_start_allow_i(warm_start_allow_i), .passthrough_on_o(passthrough_on_o),
  .a_pull_down_o(a_pull_down_o), .b_pull_down_o(b_pull_down_o), .b_pull_up_oe_o(b_pull_up_oe_o),
  .b_data_parity_drive_en_o(b_data_parity_drive_en_o), .b_busy_drive_en_o(b_busy_drive_en_o),
  .b_select_drive_en_o(b_select_drive_en_o)
);
`default_nettype wire

// ---- tb/scx_bus_model.sv ----
// Wired model of buses A and B: terminators, outside devices and the device's own drive.
`timescale 1ns/1ps
`default_nettype none

module scx_bus_model (
  input  wire logic [4:0] a_ext_i,
  input  wire logic [4:0] b_ext_i,
  input  wire logic [4:0] a_pd_i,
  input  wire logic [4:0] b_pd_i,
  input  wire logic [4:0] b_dir_i,
  input  wire logic       diff_n_i,
  output logic      [4:0] a_rx_n_o,
  output logic      [4:0] b_rx_n_o
);
  // A released line returns to the terminator level, so no stale value lingers.
  assign a_rx_n_o = ~(a_ext_i | a_pd_i);
  // In balanced mode the device reaches bus B only through an outward-turned transceiver.
  assign b_rx_n_o = ~(b_ext_i | (b_pd_i & (diff_n_i ? 5'h1f : b_dir_i)));
endmodule
`default_nettype wire

// ---- tb/scx_expander_ctrl_test.sv ----
// Self-checking bench for the expander control path.
`timescale 1ns/1ps
`default_nettype none
`include "scx_defines.vh"

module scx_expander_ctrl_test;
  logic        core_clk_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, rd;
  logic        err, a_bsy = 1'b0, b_bsy = 1'b0, diff_n = 1'b0, sed = 1'b1, ws = 1'b1;
  logic [4:0]  a_ext = 5'h00, b_ext = 5'h00;
  wire  [31:0] prdata;
  wire         pready, pslverr, pass;
  wire  [4:0]  a_rx_n, b_rx_n, a_pd, b_pd, a_pu, b_pu, b_dir;
  wire  [3:0]  spare_en;
  wire  [17:0] dp_en;
  int          errors = 0, comparisons = 0, i, n;

  always #5 core_clk_i = ~core_clk_i;

  scx_expander_ctrl scx_expander_ctrl_inst (
    .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .a_side_command_data_n_i(a_rx_n[0]), .a_side_direction_phase_n_i(a_rx_n[1]),
    .a_side_message_phase_n_i(a_rx_n[2]), .a_side_attention_n_i(a_rx_n[3]), .a_side_select_n_i(a_rx_n[4]),
    .a_side_busy_n_i(~a_bsy), .b_side_command_data_n_i(b_rx_n[0]), .b_side_direction_phase_n_i(b_rx_n[1]),
    .b_side_message_phase_n_i(b_rx_n[2]), .b_side_attention_n_i(b_rx_n[3]), .b_side_select_n_i(b_rx_n[4]),
    .b_side_busy_n_i(~b_bsy), .balanced_transceiver_mode_n_i(diff_n), .single_ended_detect_i(sed),
    .warm_start_allow_i(ws), .passthrough_on_o(pass), .a_pull_down_o(a_pd), .a_pull_up_oe_o(a_pu),
    .b_pull_down_o(b_pd), .b_pull_up_oe_o(b_pu), .b_data_parity_drive_en_o(dp_en),
    .b_busy_drive_en_o(spare_en[3]),
    .b_select_drive_en_o(b_dir[4]), .b_command_data_drive_en_o(b_dir[0]), .b_direction_phase_drive_en_o(b_dir[1]),
    .b_message_drive_en_o(b_dir[2]), .b_request_drive_en_o(spare_en[0]), .b_acknowledge_drive_en_o(spare_en[1]),
    .b_attention_drive_en_o(b_dir[3]), .b_bus_reset_drive_en_o(spare_en[2])
  );

  scx_bus_model scx_bus_model_inst (
    .a_ext_i(a_ext), .b_ext_i(b_ext), .a_pd_i(a_pd), .b_pd_i(b_pd), .b_dir_i(b_dir), .diff_n_i(diff_n),
    .a_rx_n_o(a_rx_n), .b_rx_n_o(b_rx_n)
  );

  ////////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test;
    if (errors == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic step(input int k);
    repeat (k) @(posedge core_clk_i);
    #1;
  endtask

  task automatic apb(input logic wr, input logic [11:0] adr, input logic [31:0] wd);
    int k;
    @(posedge core_clk_i);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= adr;
    pwdata <= wd;
    @(posedge core_clk_i);
    penable <= 1'b1;
    for (k = 0; k < 20 && pready !== 1'b1; k++) @(posedge core_clk_i);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k == 20) begin
      errors++;
      end_of_test();
    end
  endtask

  task automatic wait_pass(input logic exp);
    for (n = 0; n < 400 && pass !== exp; n++) step(1);
    check(pass, exp);
    if (n == 400) end_of_test();
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    step(1);
    check({pass, a_pd, b_pd}, 11'h000);
    apb(1'b0, `SCX_REG_CTRL, 32'h0);
    check(rd, `SCX_CTRL_RST);
    apb(1'b1, 12'h008, 32'hffff_ffff);
    check(err, 1'b1);
    apb(1'b0, 12'h008, 32'h0);
    check(rd, 32'h0000_0000);
    check(err, 1'b1);
    wait_pass(1'b1);
    apb(1'b0, `SCX_REG_STAT, 32'h0);
    check(rd, 32'h0000_3003);
    check({dp_en, spare_en}, 22'h000000);
    for (i = 0; i < 5; i++) begin
      @(posedge core_clk_i);
      a_ext[i] <= 1'b1;
      step(3);
      check({b_pd, b_dir, a_pd}, {5'h01 << i, 5'h01 << i, 5'h00});
      @(posedge core_clk_i);
      a_ext[i] <= 1'b0;
      step(3);
      check(b_pu, 5'h01 << i);
      step(22);
      check({a_pd, b_pd}, 10'h000);
      @(posedge core_clk_i);
      b_ext[i] <= 1'b1;
      step(3);
      check({a_pd, b_pd, b_dir}, {5'h01 << i, 10'h000});
      @(posedge core_clk_i);
      b_ext[i] <= 1'b0;
      step(3);
      check(a_pu, 5'h01 << i);
      step(27);
    end
    // One-cycle select pulse: the output stretch shows the filter, then recovery blocks a retry.
    @(posedge core_clk_i);
    a_ext[4] <= 1'b1;
    @(posedge core_clk_i);
    a_ext[4] <= 1'b0;
    #1;
    for (n = 0; n < 30 && b_pd[4] !== 1'b1; n++) step(1);
    for (n = 0; n < 30 && b_pd[4] === 1'b1; n++) step(1);
    check(n, `SCX_FILT_CYC + 1);
    @(posedge core_clk_i);
    a_ext[4] <= 1'b1;
    step(4);
    check(b_pd, 5'h00);
    step(12);
    check(b_pd, 5'h10);
    @(posedge core_clk_i);
    a_ext[4] <= 1'b0;
    step(30);
    @(posedge core_clk_i);
    a_ext[4] <= 1'b1;
    b_ext[4] <= 1'b1;
    step(3);
    check({a_pd, b_pd}, 10'h010);
    @(posedge core_clk_i);
    a_ext <= 5'h00;
    b_ext <= 5'h00;
    step(30);
    @(posedge core_clk_i);
    sed <= 1'b0;
    b_ext[0] <= 1'b1;
    a_ext[1] <= 1'b1;
    step(4);
    check({a_pd, b_pd, b_dir}, 15'h0000);
    @(posedge core_clk_i);
    a_ext <= 5'h00;
    b_ext <= 5'h00;
    sed <= 1'b1;
    diff_n <= 1'b1;
    step(30);
    @(posedge core_clk_i);
    a_ext[3] <= 1'b1;
    step(3);
    check({b_pd, b_dir}, 10'h100);
    @(posedge core_clk_i);
    a_ext[3] <= 1'b0;
    b_bsy <= 1'b1;
    ws <= 1'b0;
    step(150);
    check(pass, 1'b1);
    @(posedge core_clk_i);
    b_bsy <= 1'b0;
    wait_pass(1'b0);
    @(posedge core_clk_i);
    a_ext[2] <= 1'b1;
    step(4);
    check(b_pd, 5'h00);
    @(posedge core_clk_i);
    a_ext[2] <= 1'b0;
    ws <= 1'b1;
    wait_pass(1'b1);
    apb(1'b1, `SCX_REG_CTRL, 32'h0);
    apb(1'b0, `SCX_REG_CTRL, 32'h0);
    check(rd, 32'h0000_0000);
    check(err, 1'b0);
    wait_pass(1'b0);
    apb(1'b1, `SCX_REG_CTRL, 32'h1);
    wait_pass(1'b1);
    end_of_test();
  end
endmodule
`default_nettype wire
